// ### logic/pwm_regs.vh
// Register map, field positions, reset values and divider counts of the dual PWM block.
`ifndef PWM_REGS_VH
`define PWM_REGS_VH

// ==========================================================================
// Register byte addresses
// ==========================================================================
`define ADDR_CHAN_A_CONTROL 8'h00
`define ADDR_CHAN_B_CONTROL 8'h04
`define ADDR_CHAN_A_DUTY 8'h08
`define ADDR_CHAN_B_DUTY 8'h0c
`define ADDR_MODE 8'h10
`define ADDR_STATUS 8'h14

// ==========================================================================
// Field positions
// ==========================================================================
`define CTRL_COARSE_MSB 5
`define CTRL_COARSE_LSB 4
`define CTRL_FINE_MSB 3
`define CTRL_FINE_LSB 0
`define DUTY_VALUE_MSB 5
`define DUTY_VALUE_LSB 0
`define DUTY_POL_BIT 6
`define MODE_WAIT_BIT 0
`define MODE_STOP_BIT 1
`define STAT_PEND_A_BIT 0
`define STAT_PEND_B_BIT 1
`define STAT_COUNT_A_LSB 8
`define STAT_COUNT_B_LSB 16

// ==========================================================================
// Reset values and codes
// ==========================================================================
`define COARSE_RESET 2'h0
`define FINE_RESET 4'h0
`define MODE_RESET 2'h0
`define COARSE_OFF 2'h0
`define COARSE_DIV1 2'h1
`define COARSE_DIV8 2'h2
`define COARSE_DIV16 2'h3
`define DIV8_LAST 4'h7
`define DIV16_LAST 4'hf
`define COUNT_LAST 6'h3f

`endif

// ### logic/pwm_prescaler.v
// Two-stage prescaler: coarse divide by 1, 8 or 16, then fine divide by value plus one.
`timescale 1ns/1ps
`include "pwm_regs.vh"

module pwm_prescaler #(
    parameter FINE_W = 4
) (
    input wire clk_i,
    input wire rst_i,
    input wire run_i,
    input wire [1:0] coarse_i,
    input wire [FINE_W-1:0] fine_i,
    output reg tick_o
);

    reg [3:0] coarse_cnt_q;
    reg [FINE_W-1:0] fine_cnt_q;
    reg coarse_tick;

    // ======================================================================
    // Coarse stage
    // ======================================================================
    always @*
    begin
        case (coarse_i)
            `COARSE_DIV1: coarse_tick = 1'b1;
            `COARSE_DIV8: coarse_tick = (coarse_cnt_q[2:0] == `DIV8_LAST);
            `COARSE_DIV16: coarse_tick = (coarse_cnt_q == `DIV16_LAST);
            default: coarse_tick = 1'b0;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            coarse_cnt_q <= 4'h0;
        end
        else
        begin
            coarse_cnt_q <= coarse_cnt_q + 4'h1;
        end
    end

    // ======================================================================
    // Fine stage
    // ======================================================================
    // The compare is "at or above" so that lowering the fine value mid-count
    // takes effect at once instead of running the counter round.
    always @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            fine_cnt_q <= {FINE_W{1'b0}};
            tick_o <= 1'b0;
        end
        else if (coarse_tick)
        begin
            if (fine_cnt_q >= fine_i)
            begin
                fine_cnt_q <= {FINE_W{1'b0}};
                tick_o <= 1'b1;
            end
            else
            begin
                fine_cnt_q <= fine_cnt_q + {{(FINE_W-1){1'b0}}, 1'b1};
                tick_o <= 1'b0;
            end
        end
        else
        begin
            tick_o <= 1'b0;
        end
    end

endmodule // pwm_prescaler

// ### logic/dual_six_bit_pwm.v
// Two 6-bit PWM channels with buffered duty, polarity and an APB register slave.
// ==========================================================================
// How it works
// - Two channels, 64-step counter, two prescalers.
// - Coarse code selects stop, /1, /8, /16.
// - Fine prescaler divides by value plus one.
// - Duty zero inactive; 3F active 63/64.
// - Duty zero, polarity zero gives steady high.
// - Polarity one active high, zero active low.
// - Enabled duty writes load at period end.
// - Disabled duty writes load at once.
// - Control writes take effect immediately.
// - Only duty writes to an enabled channel wait for the cycle end.
// - Duty read returns active value, not buffer.
// - Non-zero coarse code takes over the pin.
// - Channel B behaves exactly like channel A.
// - Reset clears coarse fields, outputs go low.
// - Reset leaves duty bits unchanged.
// - Wait mode keeps channels running.
// - Stop mode aborts channels mid-phase.
// ==========================================================================
`timescale 1ns/1ps
`include "pwm_regs.vh"

module dual_six_bit_pwm #(
    parameter ADDR_W = 8,
    parameter DUTY_W = 6,
    parameter FINE_W = 4
) (
    input wire clk_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    output wire pwm_channel_a_o,
    output wire pwm_channel_b_o,
    output wire pin_takeover_a_o,
    output wire pin_takeover_b_o
);

    // ======================================================================
    // APB handshake
    // ======================================================================
    // Every access has one wait state so that ready, read data and error
    // can all come from flip-flops.
    reg pready_q;
    reg pready_d;
    reg pslverr_q;
    reg pslverr_d;
    reg [31:0] prdata_q;
    reg [31:0] prdata_d;
    reg mapped;
    reg [1:0] mode_q;
    wire commit;
    wire wr_commit;
    reg [1:0] ctrl_wr;
    reg [1:0] duty_wr;
    reg mode_wr;
    wire stop;

    assign commit = psel_i && penable_i && pready_q;
    assign wr_commit = commit && pwrite_i && pstrb_i[0];
    assign stop = mode_q[`MODE_STOP_BIT];

    // ======================================================================
    // Register write decode
    // ======================================================================
    // A committed write with the low byte lane off changes nothing.
    // Writes to the status word fall through and are dropped.
    always @*
    begin
        ctrl_wr = 2'b00;
        duty_wr = 2'b00;
        mode_wr = 1'b0;
        if (wr_commit)
        begin
            if (paddr_i == `ADDR_CHAN_A_CONTROL)
            begin
                ctrl_wr[0] = 1'b1;
            end
            else if (paddr_i == `ADDR_CHAN_B_CONTROL)
            begin
                ctrl_wr[1] = 1'b1;
            end
            else if (paddr_i == `ADDR_CHAN_A_DUTY)
            begin
                duty_wr[0] = 1'b1;
            end
            else if (paddr_i == `ADDR_CHAN_B_DUTY)
            begin
                duty_wr[1] = 1'b1;
            end
            else if (paddr_i == `ADDR_MODE)
            begin
                mode_wr = 1'b1;
            end
        end
    end

    // Per-channel state gathered from the generate loop for readback and the pin outputs.
    wire [1:0] coarse_w [0:1];
    wire [FINE_W-1:0] fine_w [0:1];
    wire [DUTY_W-1:0] act_duty_w [0:1];
    wire [1:0] act_pol_w;
    wire [1:0] pend_w;
    wire [DUTY_W-1:0] count_w [0:1];
    wire [1:0] pwm_w;
    wire [1:0] take_w;

    always @*
    begin
        pready_d = psel_i && penable_i && !pready_q;
        prdata_d = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr_i == `ADDR_CHAN_A_CONTROL)
        begin
            prdata_d[`CTRL_COARSE_MSB:`CTRL_COARSE_LSB] = coarse_w[0];
            prdata_d[`CTRL_FINE_MSB:`CTRL_FINE_LSB] = fine_w[0];
        end
        else if (paddr_i == `ADDR_CHAN_B_CONTROL)
        begin
            prdata_d[`CTRL_COARSE_MSB:`CTRL_COARSE_LSB] = coarse_w[1];
            prdata_d[`CTRL_FINE_MSB:`CTRL_FINE_LSB] = fine_w[1];
        end
        else if (paddr_i == `ADDR_CHAN_A_DUTY)
        begin
            prdata_d[`DUTY_VALUE_MSB:`DUTY_VALUE_LSB] = act_duty_w[0];
            prdata_d[`DUTY_POL_BIT] = act_pol_w[0];
        end
        else if (paddr_i == `ADDR_CHAN_B_DUTY)
        begin
            prdata_d[`DUTY_VALUE_MSB:`DUTY_VALUE_LSB] = act_duty_w[1];
            prdata_d[`DUTY_POL_BIT] = act_pol_w[1];
        end
        else if (paddr_i == `ADDR_MODE)
        begin
            prdata_d[1:0] = mode_q;
        end
        else if (paddr_i == `ADDR_STATUS)
        begin
            prdata_d[`STAT_PEND_A_BIT] = pend_w[0];
            prdata_d[`STAT_PEND_B_BIT] = pend_w[1];
            prdata_d[`STAT_COUNT_A_LSB +: DUTY_W] = count_w[0];
            prdata_d[`STAT_COUNT_B_LSB +: DUTY_W] = count_w[1];
        end
        else
        begin
            mapped = 1'b0;
        end
        pslverr_d = pready_d && !mapped;
        if (!pready_d || pwrite_i || !mapped)
        begin
            prdata_d = 32'h0000_0000;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ======================================================================
    // Low-power mode register
    // ======================================================================
    // The wait bit is stored only; the channels ignore it and keep running.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= `MODE_RESET;
        end
        else if (mode_wr)
        begin
            mode_q <= pwdata_i[1:0];
        end
    end

    // ======================================================================
    // Channels
    // ======================================================================
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1)
        begin : g_chan
            reg [1:0] coarse_q;
            reg [FINE_W-1:0] fine_q;
            reg [DUTY_W-1:0] buf_duty_q;
            reg buf_pol_q;
            reg [DUTY_W-1:0] act_duty_q;
            reg act_pol_q;
            reg pend_q;
            reg [DUTY_W-1:0] count_q;
            reg pwm_q;
            reg take_q;
            wire enabled;
            wire tick;
            wire period_end;
            wire load_buf;
            wire active;

            assign enabled = (coarse_q != `COARSE_OFF);
            assign period_end = tick && (count_q == `COUNT_LAST);
            assign load_buf = pend_q && (!enabled || period_end);
            assign active = (count_q < act_duty_q);

            pwm_prescaler #(
                .FINE_W(FINE_W)
            ) u_prescaler (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .run_i(enabled && !stop),
                .coarse_i(coarse_q),
                .fine_i(fine_q),
                .tick_o(tick)
            );

            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    coarse_q <= `COARSE_RESET;
                    fine_q <= `FINE_RESET;
                end
                else if (ctrl_wr[i])
                begin
                    coarse_q <= pwdata_i[`CTRL_COARSE_MSB:`CTRL_COARSE_LSB];
                    fine_q <= pwdata_i[`CTRL_FINE_MSB:`CTRL_FINE_LSB];
                end
            end

            // Duty and polarity carry no reset and survive it unchanged.
            always @(posedge clk_i)
            begin
                if (duty_wr[i])
                begin
                    buf_duty_q <= pwdata_i[`DUTY_VALUE_MSB:`DUTY_VALUE_LSB];
                    buf_pol_q <= pwdata_i[`DUTY_POL_BIT];
                end
                if (duty_wr[i] && !enabled)
                begin
                    act_duty_q <= pwdata_i[`DUTY_VALUE_MSB:`DUTY_VALUE_LSB];
                    act_pol_q <= pwdata_i[`DUTY_POL_BIT];
                end
                else if (load_buf)
                begin
                    act_duty_q <= buf_duty_q;
                    act_pol_q <= buf_pol_q;
                end
            end

            // A write landing on the period boundary stays pending.
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    pend_q <= 1'b0;
                end
                else if (duty_wr[i] && enabled)
                begin
                    pend_q <= 1'b1;
                end
                else if (load_buf || (duty_wr[i] && !enabled))
                begin
                    pend_q <= 1'b0;
                end
            end

            // The counter restarts from zero whenever the channel is off or stopped.
            always @(posedge clk_i)
            begin
                if (rst_i || !enabled || stop)
                begin
                    count_q <= {DUTY_W{1'b0}};
                end
                else if (tick)
                begin
                    count_q <= count_q + {{(DUTY_W-1){1'b0}}, 1'b1};
                end
            end

            // In stop the pin level freezes in whatever phase it had.
            always @(posedge clk_i)
            begin
                if (rst_i || !enabled)
                begin
                    pwm_q <= 1'b0;
                    take_q <= 1'b0;
                end
                else
                begin
                    take_q <= 1'b1;
                    if (!stop)
                    begin
                        pwm_q <= act_pol_q ? active : !active;
                    end
                end
            end

            assign coarse_w[i] = coarse_q;
            assign fine_w[i] = fine_q;
            assign act_duty_w[i] = act_duty_q;
            assign act_pol_w[i] = act_pol_q;
            assign pend_w[i] = pend_q;
            assign count_w[i] = count_q;
            assign pwm_w[i] = pwm_q;
            assign take_w[i] = take_q;
        end
    endgenerate

    // ======================================================================
    // Outputs
    // ======================================================================
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign pwm_channel_a_o = pwm_w[0];
    assign pwm_channel_b_o = pwm_w[1];
    assign pin_takeover_a_o = take_w[0];
    assign pin_takeover_b_o = take_w[1];

endmodule // dual_six_bit_pwm

// ### tb/pwm_props.sv
// Port-level checker for the dual PWM block.
`timescale 1ns/1ps
module pwm_props #(
    parameter ADDR_W = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire pwm_channel_a_o,
    input wire pwm_channel_b_o,
    input wire pin_takeover_a_o,
    input wire pin_takeover_b_o
);
    // ====
    // Bus and pin checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire acc_w = psel_i && penable_i;
    wire wr_w = acc_w && pready_o && pwrite_i && pstrb_i[0];
    property take_p(logic [ADDR_W-1:0] a, logic tk);
        wr_w && paddr_i == a |=> ##1 tk == ($past(pwdata_i[5:4], 2) != 2'h0);
    endproperty
    ready_wait_a: assert property (acc_w && !pready_o && !$past(penable_i) |=> pready_o)
        else $error("ready not one cycle into access");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held over two cycles");
    ready_cause_a: assert property (!acc_w |=> !pready_o)
        else $error("ready without access");
    err_addr_a: assert property (acc_w && pready_o && paddr_i[1:0] == 2'h0
        |-> pslverr_o == (paddr_i > 8'h14)) else $error("error flag wrong");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside ready");
    take_a_a: assert property (take_p(8'h00, pin_takeover_a_o))
        else $error("pin a ownership wrong");
    take_b_a: assert property (take_p(8'h04, pin_takeover_b_o))
        else $error("pin b ownership wrong");
    off_low_a: assert property (!pin_takeover_a_o [*3] |-> !pwm_channel_a_o)
        else $error("output a high while off");
    off_low_b_a: assert property (!pin_takeover_b_o [*3] |-> !pwm_channel_b_o)
        else $error("output b high while off");
    reset_clear_a: assert property (disable iff (1'b0) rst_i |=> !pwm_channel_a_o
        && !pwm_channel_b_o && !pin_takeover_a_o && !pin_takeover_b_o)
        else $error("outputs not cleared by reset");
    cover property (wr_w);
    cover property (pready_o && pslverr_o);
    cover property ($rose(pin_takeover_b_o));
endmodule // pwm_props

// ### tb/pwm_load.sv
// Pin load model: resolves the shared pins and counts cycles they sit high.
`timescale 1ns/1ps
module pwm_load (
    input wire clk_i,
    input wire clear_i,
    input wire pwm_a_i,
    input wire pwm_b_i,
    input wire own_a_i,
    input wire own_b_i,
    output logic [15:0] high_a_o,
    output logic [15:0] high_b_o
);
    // A pin not handed to the PWM is left to the port, seen here as a pull-down.
    wire pin_a = own_a_i ? pwm_a_i : 1'b0;
    wire pin_b = own_b_i ? pwm_b_i : 1'b0;
    always @(posedge clk_i)
    begin
        if (clear_i)
        begin
            high_a_o <= 16'h0000;
            high_b_o <= 16'h0000;
        end
        else
        begin
            high_a_o <= high_a_o + {15'h0000, pin_a};
            high_b_o <= high_b_o + {15'h0000, pin_b};
        end
    end
endmodule // pwm_load

// ### tb/testbench.sv
// Self-checking bench: APB register tests and pin duty measurement.
`timescale 1ns/1ps
`include "pwm_regs.vh"
module testbench;
    // ====
    // Signals and instances
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0] pstrb_i = 4'hf;
    logic clear_q = 1'b0;
    wire [31:0] prdata_o;
    wire pready_o;
    wire pslverr_o;
    wire [1:0] pwm_w;
    wire [1:0] own_w;
    wire [15:0] high_w [2];
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    always #2 clk_i = ~clk_i;
    dual_six_bit_pwm u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pwm_channel_a_o(pwm_w[0]), .pwm_channel_b_o(pwm_w[1]),
        .pin_takeover_a_o(own_w[0]), .pin_takeover_b_o(own_w[1]));
    pwm_load u_load (
        .clk_i(clk_i), .clear_i(clear_q), .pwm_a_i(pwm_w[0]), .pwm_b_i(pwm_w[1]),
        .own_a_i(own_w[0]), .own_b_i(own_w[1]), .high_a_o(high_w[0]), .high_b_o(high_w[1]));
    // ====
    // Bus and measurement tasks
    task automatic check(input string name, input logic [31:0] expv, input logic [31:0] got);
        n_checks++;
        if (got !== expv)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", name, expv, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] rd, output logic er);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1)
            @(posedge clk_i);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, 4'hf, rd, er);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] expv);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, 4'hf, rd, er);
        check(name, expv, rd);
    endtask
    task automatic meas(input string name, input int ch, input int n, input int expv);
        @(posedge clk_i);
        clear_q <= 1'b1;
        @(posedge clk_i);
        clear_q <= 1'b0;
        repeat (n) @(posedge clk_i);
        #1;
        check(name, 32'(expv), {16'h0, high_w[ch]});
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    // ====
    // Test sequence
    initial
    begin : main
        logic [31:0] rd;
        logic er;
        logic [7:0] ca;
        logic [7:0] da;
        logic lvl;
        int div;
        logic [7:0] duty_tab [5] = '{8'h60, 8'h40, 8'h00, 8'h10, 8'h7f};
        int hi_tab [5] = '{32, 0, 64, 48, 63};
        logic [7:0] ctl_tab [4] = '{8'h10, 8'h1f, 8'h20, 8'h31};
        int div_tab [4] = '{1, 16, 8, 32};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("ctrl_a", `ADDR_CHAN_A_CONTROL, 32'h0);
        rd_chk("ctrl_b", `ADDR_CHAN_B_CONTROL, 32'h0);
        wr(`ADDR_CHAN_A_DUTY, 32'h45);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("duty_kept", `ADDR_CHAN_A_DUTY, 32'h45);
        apb(1'b0, 8'h18, 32'h0, 4'hf, rd, er);
        check("unmapped_err", 32'h1, {31'h0, er});
        apb(1'b1, `ADDR_CHAN_A_CONTROL, 32'h10, 4'h0, rd, er);
        rd_chk("masked_write", `ADDR_CHAN_A_CONTROL, 32'h0);
        $display("register test done");
        for (int ch = 0; ch < 2; ch++)
        begin
            ca = 8'(4 * ch);
            da = 8'(8 + 4 * ch);
            wr(da, 32'h60);
            rd_chk("duty_now", da, 32'h60);
            wr(ca, 32'h10);
            for (int i = 0; i < 5; i++)
            begin
                wr(da, {24'h0, duty_tab[i]});
                repeat (128) @(posedge clk_i);
                meas("duty_high", ch, 64, hi_tab[i]);
            end
            check("pin_owned", 32'h1, {31'h0, own_w[ch]});
            // Align to the period end, so the buffered write lands early in a period.
            do @(posedge clk_i); while (pwm_w[ch] !== 1'b0);
            wr(da, 32'h50);
            rd_chk("duty_active", da, 32'h7f);
            repeat (128) @(posedge clk_i);
            rd_chk("duty_loaded", da, 32'h50);
            $display("duty test done");
            for (int i = 0; i < 4; i++)
            begin
                div = div_tab[i];
                wr(ca, {24'h0, ctl_tab[i]});
                repeat (128 * div) @(posedge clk_i);
                meas("rate_high", ch, 64 * div, 16 * div);
            end
            wr(ca, 32'h10);
            wr(`ADDR_MODE, 32'h2);
            repeat (2) @(posedge clk_i);
            #1;
            lvl = pwm_w[ch];
            meas("stop_frozen", ch, 128, lvl ? 128 : 0);
            rd_chk("stop_count", `ADDR_STATUS, 32'h0);
            wr(`ADDR_MODE, 32'h1);
            repeat (128) @(posedge clk_i);
            meas("wait_high", ch, 64, 16);
            wr(ca, 32'h0);
            repeat (3) @(posedge clk_i);
            #1;
            check("pin_off", 32'h0, {30'h0, own_w[ch], pwm_w[ch]});
            $display("channel %0d test done", ch);
        end
        report_and_stop();
    end
endmodule // testbench

bind dual_six_bit_pwm pwm_props #(.ADDR_W(ADDR_W)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pwm_channel_a_o(pwm_channel_a_o), .pwm_channel_b_o(pwm_channel_b_o),
    .pin_takeover_a_o(pin_takeover_a_o), .pin_takeover_b_o(pin_takeover_b_o));
